// ===== core/rtcte_pkg.sv
// Constants, register map and carrier types for the counter task/event front end.
// Assumes a single 100 MHz clock and a slow clock input sampled on it.
package rtcte_pkg;

  // Register offsets
  localparam logic [11:0] OFS_RUN       = 12'h000;
  localparam logic [11:0] OFS_HALT      = 12'h004;
  localparam logic [11:0] OFS_ZERO      = 12'h008;
  localparam logic [11:0] OFS_PRELOAD   = 12'h00C;
  localparam logic [3:0][11:0] OFS_HOOK = {12'h08C, 12'h088, 12'h084, 12'h080};
  localparam logic [11:0] OFS_INC_FLAG  = 12'h100;
  localparam logic [11:0] OFS_WRAP_FLAG = 12'h104;
  localparam logic [11:0] OFS_COUNT     = 12'h504;
  localparam logic [11:0] OFS_PRESCALE  = 12'h508;

  // Field positions and widths
  localparam int TASK_BIT    = 0;
  localparam int FLAG_BIT    = 0;
  localparam int CNT_W       = 24;
  localparam int PRE_W       = 12;
  localparam int CH_N        = 16;
  localparam int CH_IDX_W    = 4;
  localparam int TASK_N      = 4;

  // Task slots
  localparam int T_RUN     = 0;
  localparam int T_HALT    = 1;
  localparam int T_ZERO    = 2;
  localparam int T_PRELOAD = 3;

  // Values
  localparam logic [CNT_W-1:0] PRELOAD_VALUE = 24'hFFFFF0;
  localparam logic [CNT_W-1:0] COUNT_MAX     = 24'hFFFFFF;
  localparam logic [CNT_W-1:0] COUNT_RESET   = 24'h000000;
  localparam logic [PRE_W-1:0] PRESCALE_RESET = 12'h000;
  localparam logic [31:0]      WORD_ZERO     = 32'h00000000;
  localparam int               SLOW_CLOCK_HZ = 32768;

  // Timing
  localparam real CLK_PERIOD_NS   = 10.0;
  localparam real TASK_DLY_MIN_US = 15.2585;
  localparam real TASK_DLY_MAX_US = 45.7755;
  localparam int  TASK_DLY_MIN_CYC = int'($ceil(TASK_DLY_MIN_US * 1000.0 / CLK_PERIOD_NS));
  localparam int  TASK_DLY_MAX_CYC = int'($floor(TASK_DLY_MAX_US * 1000.0 / CLK_PERIOD_NS));

  // Subscription register layout
  typedef struct packed {
    logic                en;
    logic [26:0]         unused;
    logic [CH_IDX_W-1:0] channel_index;
  } rtcte_hook_t;

  localparam rtcte_hook_t HOOK_RESET = '0;

  // Register port request
  typedef struct packed {
    logic        sel;
    logic        write;
    logic [11:0] addr;
    logic [31:0] wdata;
  } rtcte_req_t;

  // Task pulses towards the counter core
  typedef struct packed {
    logic preload;
    logic zero;
    logic halt;
    logic run;
  } rtcte_tasks_t;

endpackage : rtcte_pkg

// ===== core/rtcte_hook.sv
// One task subscription: config register plus channel select.
// Assumes channel events are one-cycle pulses synchronous to clk.
`timescale 1ns/1ps
module rtcte_hook
  import rtcte_pkg::*;
(
  input  wire logic            clk,
  input  wire logic            reset,
  input  wire logic            wr_hit,
  input  wire logic [31:0]     wdata,
  input  wire logic [CH_N-1:0] channels,
  output rtcte_hook_t          cfg,
  output logic                 fire
);

  logic selected;

  assign selected = channels[cfg.channel_index];

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cfg <= HOOK_RESET;
    end else if (wr_hit) begin
      cfg <= rtcte_hook_t'(wdata);
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      fire <= 1'b0;
    end else begin
      fire <= cfg.en & selected;
    end
  end

  hook_fires_a : assert property (@(posedge clk) disable iff (reset)
    (cfg.en && selected) |=> fire)
    else $error("enabled subscription did not fire");

  hook_quiet_a : assert property (@(posedge clk) disable iff (reset)
    !cfg.en |=> !fire)
    else $error("disabled subscription fired");

endmodule : rtcte_hook

// ===== core/rtcte_core.sv
// Task, subscription and event-flag front end with its 24-bit counter.
// Assumes the register port and slow_clock are synchronous to clk.
//
// Functional notes
// - Writing one to run_trigger starts the counter incrementing.
// - Writing one to halt_trigger stops incrementing and keeps the count.
// - Writing one to zero_trigger sets the counter to zero.
// - Writing one to preload_wrap_trigger loads 0xFFFFF0 into the counter.
// - run_channel_hook holds channel index and enable; enabled channel event starts.
// - halt_channel_hook, same layout, lets a channel event halt the counter.
// - zero_channel_hook lets a channel event zero the counter.
// - preload_channel_hook lets a channel event preload the counter.
// - Every counter increment sets increment_flag.
// - Counter overflow sets wrap_flag bit 0; reset value zero.
// - Counter rate is 32768/(prescaler+1); prescaler written only while stopped.
// - Halt, zero, preload act after one slow clock fall then rise.
`timescale 1ns/1ps
module rtcte_core
  import rtcte_pkg::*;
#(
  parameter int TASK_DELAY_MAX_CYC = TASK_DLY_MAX_CYC
)
(
  input  wire logic            clk,
  input  wire logic            reset,
  input  rtcte_req_t           req,
  input  wire logic [CH_N-1:0] channels,
  input  wire logic            slow_clock,
  output logic [31:0]          rdata,
  output logic                 rvalid,
  output rtcte_tasks_t         task_pulse,
  output logic                 increment_pulse,
  output logic                 wrap_pulse,
  output logic [CNT_W-1:0]     count,
  output logic                 running
);

  // Decode
  logic              wr;
  logic              rd;
  logic [TASK_N-1:0] sw_task;
  logic [TASK_N-1:0] hook_hit;
  logic [TASK_N-1:0] hook_fire;
  logic [TASK_N-1:0] req_task;
  logic              wr_inc_flag;
  logic              wr_wrap_flag;
  logic              wr_prescale;
  rtcte_hook_t       hook_cfg [TASK_N];

  assign wr = req.sel & req.write;
  assign rd = req.sel & ~req.write;

  assign sw_task[T_RUN]     = wr & (req.addr == OFS_RUN)     & req.wdata[TASK_BIT];
  assign sw_task[T_HALT]    = wr & (req.addr == OFS_HALT)    & req.wdata[TASK_BIT];
  assign sw_task[T_ZERO]    = wr & (req.addr == OFS_ZERO)    & req.wdata[TASK_BIT];
  assign sw_task[T_PRELOAD] = wr & (req.addr == OFS_PRELOAD) & req.wdata[TASK_BIT];

  assign req_task     = sw_task | hook_fire;
  assign wr_inc_flag  = wr & (req.addr == OFS_INC_FLAG);
  assign wr_wrap_flag = wr & (req.addr == OFS_WRAP_FLAG);

  assign wr_prescale  = wr & (req.addr == OFS_PRESCALE) & ~running;

  genvar gi;
  generate
    for (gi = 0; gi < TASK_N; gi++) begin : g_hook
      assign hook_hit[gi] = wr & (req.addr == OFS_HOOK[gi]);
      rtcte_hook u_hook (
        .clk      (clk),
        .reset    (reset),
        .wr_hit   (hook_hit[gi]),
        .wdata    (req.wdata),
        .channels (channels),
        .cfg      (hook_cfg[gi]),
        .fire     (hook_fire[gi])
      );
    end
  endgenerate

  // Slow clock edges
  logic slow_d;
  logic slow_rise;
  logic slow_fall;

  assign slow_rise = slow_clock & ~slow_d;
  assign slow_fall = ~slow_clock & slow_d;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      slow_d <= 1'b0;
    end else begin
      slow_d <= slow_clock;
    end
  end

  // Delayed tasks: halt, zero, preload (bits 0..2)
  logic [2:0] pend;
  logic [2:0] fell;
  logic [2:0] apply;
  logic [2:0] req_dly;
  logic [2:0] next_pend;
  logic [2:0] next_fell;

  assign req_dly = req_task[T_PRELOAD:T_HALT];

  assign apply     = fell & {3{slow_rise}};
  assign next_pend = (pend & ~apply) | req_dly;
  assign next_fell = (fell | (pend & {3{slow_fall}})) & ~apply;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pend <= 3'h0;
      fell <= 3'h0;
    end else begin
      pend <= next_pend;
      fell <= next_fell;
    end
  end

  logic apply_halt;
  logic apply_zero;
  logic apply_preload;

  assign apply_halt    = apply[T_HALT - 1];
  assign apply_zero    = apply[T_ZERO - 1];
  assign apply_preload = apply[T_PRELOAD - 1];

  // Counter datapath
  logic [PRE_W-1:0] prescale;
  logic [PRE_W-1:0] pre_cnt;
  logic             advance;
  logic             tick;
  logic             wrap;

  assign advance = slow_rise & running & ~apply_halt & ~apply_zero & ~apply_preload;
  assign tick    = advance & (pre_cnt == prescale);

  assign wrap    = tick & (count == COUNT_MAX);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      prescale <= PRESCALE_RESET;
    end else if (wr_prescale) begin
      prescale <= req.wdata[PRE_W-1:0];
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      running <= 1'b0;
    end else if (req_task[T_RUN]) begin
      running <= 1'b1;
    end else if (apply_halt) begin
      running <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      count   <= COUNT_RESET;
      pre_cnt <= PRESCALE_RESET;
    end else if (apply_zero) begin
      count   <= COUNT_RESET;
      pre_cnt <= PRESCALE_RESET;
    end else if (apply_preload) begin
      count   <= PRELOAD_VALUE;
      pre_cnt <= PRESCALE_RESET;
    end else if (tick) begin
      count   <= count + 24'h000001;
      pre_cnt <= PRESCALE_RESET;
    end else if (advance) begin
      pre_cnt <= pre_cnt + 12'h001;
    end
  end

  // Event flags, set wins over clear
  logic inc_flag;
  logic wrap_flag;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      inc_flag <= 1'b0;
    end else if (tick) begin
      inc_flag <= 1'b1;
    end else if (wr_inc_flag) begin
      inc_flag <= req.wdata[FLAG_BIT];
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wrap_flag <= 1'b0;
    end else if (wrap) begin
      wrap_flag <= 1'b1;
    end else if (wr_wrap_flag) begin
      wrap_flag <= req.wdata[FLAG_BIT];
    end
  end

  // Pulses towards the counter core
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      task_pulse      <= '0;
      increment_pulse <= 1'b0;
      wrap_pulse      <= 1'b0;
    end else begin
      task_pulse.run     <= req_task[T_RUN];
      task_pulse.halt    <= apply_halt;
      task_pulse.zero    <= apply_zero;
      task_pulse.preload <= apply_preload;
      increment_pulse    <= tick;
      wrap_pulse         <= wrap;
    end
  end

  // Read path; task registers and unmapped offsets read zero
  logic [31:0] rd_word;
  logic [31:0] hook_word;
  logic        hook_sel;

  always_comb begin
    hook_word = WORD_ZERO;
    hook_sel  = 1'b0;
    for (int i = 0; i < TASK_N; i++) begin
      if (req.addr == OFS_HOOK[i]) begin
        hook_word = 32'(hook_cfg[i]);
        hook_sel  = 1'b1;
      end
    end
  end

  assign rd_word = hook_sel                    ? hook_word :
                   (req.addr == OFS_INC_FLAG)  ? {31'h00000000, inc_flag} :
                   (req.addr == OFS_WRAP_FLAG) ? {31'h00000000, wrap_flag} :
                   (req.addr == OFS_COUNT)     ? {8'h00, count} :
                   (req.addr == OFS_PRESCALE)  ? {20'h00000, prescale} :
                   WORD_ZERO;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rdata  <= WORD_ZERO;
      rvalid <= 1'b0;
    end else begin
      rdata  <= rd ? rd_word : WORD_ZERO;
      rvalid <= rd;
    end
  end

  // Halt wait watchdog for checking
  logic [12:0] halt_wait;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      halt_wait <= 13'h0000;
    end else if (!pend[T_HALT - 1]) begin
      halt_wait <= 13'h0000;
    end else if (halt_wait != 13'h1FFF) begin
      halt_wait <= halt_wait + 13'h0001;
    end
  end

  run_starts_a : assert property (@(posedge clk) disable iff (reset)
    req_task[T_RUN] |=> running ##1 (running || $past(apply_halt)))
    else $error("run task did not start counter");

  halt_keeps_a : assert property (@(posedge clk) disable iff (reset)
    (apply_halt && !req_task[T_RUN] && !apply_zero && !apply_preload)
      |=> !running && $stable(count))
    else $error("halt did not stop or changed count");

  zero_clears_a : assert property (@(posedge clk) disable iff (reset)
    apply_zero |=> (count == COUNT_RESET) && (pre_cnt == PRESCALE_RESET))
    else $error("zero task did not clear counter");

  preload_load_a : assert property (@(posedge clk) disable iff (reset)
    (apply_preload && !apply_zero) |=> (count == PRELOAD_VALUE))
    else $error("preload task wrong value");

  tick_flag_a : assert property (@(posedge clk) disable iff (reset)
    tick |=> inc_flag && increment_pulse && (count == $past(count) + 24'h000001))
    else $error("increment did not set flag");

  wrap_flag_a : assert property (@(posedge clk) disable iff (reset)
    (tick && count == COUNT_MAX) |=> wrap_flag && wrap_pulse && (count == COUNT_RESET))
    else $error("overflow did not wrap and set flag");

  prescale_step_a : assert property (@(posedge clk) disable iff (reset)
    (advance && pre_cnt != prescale) |=> $stable(count) && (pre_cnt == $past(pre_cnt) + 12'h001))
    else $error("prescaler advanced counter early");

  task_delay_a : assert property (@(posedge clk) disable iff (reset)
    ($rose(pend[T_HALT - 1]) && !slow_rise) |=> !apply_halt)
    else $error("halt acted without slow clock fall and rise");

  halt_bound_a : assert property (@(posedge clk) disable iff (reset)
    32'(halt_wait) <= TASK_DELAY_MAX_CYC)
    else $error("halt pending too long");

  flag_hold_a : assert property (@(posedge clk) disable iff (reset)
    (inc_flag && !(wr_inc_flag && !req.wdata[FLAG_BIT])) |=> inc_flag)
    else $error("increment flag dropped without clear");

endmodule : rtcte_core

// ===== bench/rtcte_far.sv
// Far-side model: free-running slow clock source and event channel pulser.
// Assumes the bench requests a pulse by holding go high across one rising edge.
`timescale 1ns/1ps
module rtcte_far
  import rtcte_pkg::*;
#(
  parameter int HALF_CYC = 20
)
(
  input  wire logic            clk,
  input  wire logic            reset,
  input  wire logic            go,
  input  wire logic [3:0]      idx,
  output logic                 slow_clock,
  output logic [CH_N-1:0]      channels
);
  int   phase;
  logic go_q;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      go_q <= 1'b0;
    end else begin
      go_q <= go;
    end
  end

  always @(negedge clk or posedge reset) begin
    if (reset) begin
      phase      <= 0;
      slow_clock <= 1'b0;
      channels   <= '0;
    end else begin
      phase      <= (phase == HALF_CYC - 1) ? 0 : phase + 1;
      slow_clock <= (phase == HALF_CYC - 1) ? ~slow_clock : slow_clock;
      channels   <= go_q ? (CH_N'(1) << idx) : '0;
    end
  end
endmodule : rtcte_far

// ===== bench/tb_top.sv
// Self-checking bench for the counter task/event front end.
// Assumes the slow clock model runs 40 clk cycles per period.
`timescale 1ns/1ps
module tb_top;
  import rtcte_pkg::*;
  localparam int SLOW = 40;
  logic             clk;
  logic             reset;
  rtcte_req_t       req;
  logic [CH_N-1:0]  channels;
  logic             slow_clock;
  logic [31:0]      rdata;
  logic             rvalid;
  rtcte_tasks_t     task_pulse;
  logic             increment_pulse;
  logic             wrap_pulse;
  logic [CNT_W-1:0] count;
  logic             running;
  logic             go;
  logic [3:0]       idx;
  logic [5:0]       ev;
  logic [31:0]      v;
  logic [CNT_W-1:0] held;
  logic             hit;
  int               n;
  int               cyc;
  int               n_mismatch;
  int               samples_checked;
  logic [11:0]      zero_adr [11] = '{12'h000, 12'h004, 12'h008, 12'h00C, 12'h080, 12'h084,
                                      12'h088, 12'h08C, 12'h100, 12'h104, 12'h200};

  assign ev = {wrap_pulse, increment_pulse, task_pulse};

  rtcte_core uut (.clk(clk), .reset(reset), .req(req), .channels(channels),
    .slow_clock(slow_clock), .rdata(rdata), .rvalid(rvalid), .task_pulse(task_pulse),
    .increment_pulse(increment_pulse), .wrap_pulse(wrap_pulse), .count(count),
    .running(running));
  rtcte_far #(.HALF_CYC(SLOW / 2)) far (.clk(clk), .reset(reset), .go(go), .idx(idx),
    .slow_clock(slow_clock), .channels(channels));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    req = '{sel: 1'b1, write: 1'b1, addr: a, wdata: d};
    @(negedge clk);
    req = '0;
    // Idle edge so back-to-back calls never re-raise sel in the same step
    @(negedge clk);
  endtask : wr

  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    req = '{sel: 1'b1, write: 1'b0, addr: a, wdata: WORD_ZERO};
    @(negedge clk);
    chk("rvalid", rvalid, 1);
    d = rdata;
    req = '0;
    @(negedge clk);
  endtask : rd

  task automatic wait_ev(input int i, input int lim, output logic h, output int k);
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (ev[i] !== 1'b1 && k < lim);
    h = (ev[i] === 1'b1);
  endtask : wait_ev

  task automatic pulse(input logic [3:0] c);
    idx = c;
    go  = 1'b1;
    @(negedge clk);
    go  = 1'b0;
  endtask : pulse

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : tally_and_finish

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  initial begin
    reset = 1'b1;
    req = '0;
    go = 1'b0;
    idx = 4'h0;
    n_mismatch = 0;
    samples_checked = 0;
    repeat (6) @(negedge clk);
    reset = 1'b0;
    foreach (zero_adr[i]) begin
      rd(zero_adr[i], v);
      chk("reset value", v, WORD_ZERO);
    end
    wr(OFS_RUN, WORD_ZERO);
    repeat (3) @(negedge clk);
    chk("run on zero write", running, 0);
    wr(OFS_RUN, 32'h00000001);
    chk("running", running, 1);
    wait_ev(4, 200, hit, n);
    rd(OFS_INC_FLAG, v);
    chk("increment flag", v, 1);
    wr(OFS_INC_FLAG, WORD_ZERO);
    rd(OFS_INC_FLAG, v);
    chk("increment flag clear", v, 0);
    wr(OFS_PRELOAD, 32'h00000001);
    chk("preload early", count == PRELOAD_VALUE, 0);
    wait_ev(3, 200, hit, n);
    chk("preload delay", (n >= SLOW / 2) && (n <= 2 * SLOW), 1);
    chk("preload count", count, PRELOAD_VALUE);
    wait_ev(5, 1000, hit, n);
    chk("wrap cycles", n, 16 * SLOW);
    chk("wrap count", count, COUNT_RESET);
    rd(OFS_WRAP_FLAG, v);
    chk("wrap flag", v, 1);
    wr(OFS_WRAP_FLAG, WORD_ZERO);
    rd(OFS_WRAP_FLAG, v);
    chk("wrap flag clear", v, 0);
    wr(OFS_HALT, 32'h00000001);
    wait_ev(1, 200, hit, n);
    chk("halted", running, 0);
    held = count;
    repeat (200) @(negedge clk);
    chk("count held", count, held);
    rd(OFS_COUNT, v);
    chk("count read", v, {8'h00, held});
    wr(OFS_PRESCALE, 32'h00000003);
    rd(OFS_PRESCALE, v);
    chk("prescaler", v, 3);
    wr(OFS_ZERO, 32'h00000001);
    wait_ev(2, 200, hit, n);
    chk("zeroed", count, COUNT_RESET);
    wr(OFS_RUN, 32'h00000001);
    wait_ev(4, 400, hit, n);
    wait_ev(4, 400, hit, n);
    chk("tick spacing", n, 4 * SLOW);
    for (int t = 0; t < TASK_N; t++) begin
      if (t == 0) begin
        wr(OFS_HALT, 32'h00000001);
        wait_ev(1, 200, hit, n);
      end
      wr(OFS_HOOK[t], 32'h80000005 + t);
      rd(OFS_HOOK[t], v);
      chk("hook readback", v, 32'h80000005 + t);
      pulse(4'(5 + t));
      wait_ev(t, 300, hit, n);
      chk("hook fired", hit, 1);
      chk("hook running", running, t == T_RUN);
      if (t >= T_ZERO) begin
        chk("hook count", count, t == T_ZERO ? COUNT_RESET : PRELOAD_VALUE);
      end
    end
    wr(OFS_HOOK[T_RUN], 32'h00000005);
    pulse(4'h5);
    wait_ev(T_RUN, 100, hit, n);
    chk("disabled hook", hit, 0);
    chk("disabled running", running, 0);
    tally_and_finish();
  end
endmodule : tb_top
